/* File: core/standby_ctrl.sv */
// Standby sequencer: halt and stop entry, wake decision, restart wait, resume address.
// Assumes request and enable flags come from core-clock logic;
// the reset pin and power-fail detector are asynchronous and are synchronised here.
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module standby_ctrl #(
	parameter int unsigned NUM_SRC = 4,
	parameter int unsigned TMR_IDX = 0,
	parameter logic [15:0] RST_DIV = standby_pkg::RST_DIV_DEF,
	parameter logic [15:0] RST_CNT = standby_pkg::RST_CNT_DEF
) (
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	input wire logic CLK_EN_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic RESET_PIN_N_I,
	input wire logic POWER_FAIL_I,
	input wire logic HALT_EXEC_I,
	input wire logic STOP_EXEC_I,
	input wire logic [3:0] OPERAND_I,
	input wire logic [NUM_SRC-1:0] PERIPHERAL_REQUEST_FLAG_I,
	input wire logic [NUM_SRC-1:0] PERIPHERAL_WAKE_ENABLE_FLAG_I,
	input wire logic GLOBAL_INTERRUPTS_ENABLED_I,
	output logic CORE_CLK_EN_O,
	output logic OSC_EN_O,
	output logic HALT_MODE_O,
	output logic STOP_MODE_O,
	output logic INIT_O,
	output logic RESUME_O,
	output standby_pkg::resume_type RESUME_SEL_O,
	output logic [$clog2(NUM_SRC)-1:0] VECTOR_O
);
	import standby_pkg::*;

	localparam int IW = $clog2(NUM_SRC);
	localparam logic [NUM_SRC-1:0] TMR_MASK = NUM_SRC'(1) << TMR_IDX;

	// Lowest index is the highest priority
	function automatic logic [IW-1:0] first_src(input logic [NUM_SRC-1:0] v);
		logic [IW-1:0] r;
		r = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = IW'(i);
			end
		end
		return r;
	endfunction

	function automatic logic irq_hit(input logic [3:0] op, input logic [NUM_SRC-1:0] pend);
		return op[OP_IRQ_BIT] && (|pend);
	endfunction

	standby_timer_if tmr ();

	standby_wait_timer u_wait_timer (
		.clk_i(CORE_CLK_I),
		.arst_n_i(ARST_N_I),
		.clk_en_i(CLK_EN_I),
		.tmr(tmr)
	);

	// Reset pin and power-fail detector synchronisers
	logic [1:0] rpin_q, rpin_d, pfail_q, pfail_d;
	logic rst_req;

	always_comb begin
		rpin_d = {rpin_q[0], RESET_PIN_N_I};
		pfail_d = {pfail_q[0], POWER_FAIL_I};
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rpin_q <= 2'h0;
			pfail_q <= 2'h3;
		end else if (CLK_EN_I) begin
			rpin_q <= rpin_d;
			pfail_q <= pfail_d;
		end
	end

	assign rst_req = !rpin_q[1] || pfail_q[1];

	// Wake terms
	logic [NUM_SRC-1:0] pend, pend_stop;
	logic tmr_req;

	assign pend = PERIPHERAL_REQUEST_FLAG_I & PERIPHERAL_WAKE_ENABLE_FLAG_I;
	assign pend_stop = pend & ~TMR_MASK;
	assign tmr_req = PERIPHERAL_REQUEST_FLAG_I[TMR_IDX];

	// Sequencer state
	state_type state_q, state_d;
	logic [3:0] op_q, op_d;
	cause_type cause_q, cause_d;
	resume_type sel_q, sel_d;
	logic [IW-1:0] vec_q, vec_d;
	logic pulse_q, pulse_d, init_q, init_d, cold_q, cold_d;
	logic [15:0] wdiv_q, wdiv_d, wcnt_q, wcnt_d;
	logic [15:0] ctrl_q, osc_q;
	logic [7:0] mod_n, div_m;
	logic halt_irq, halt_tmr, stop_irq;
	logic new_halt_wake, new_stop_wake;

	assign mod_n = ctrl_q[CTRL_N_LSB +: 8];
	assign div_m = ctrl_q[CTRL_M_LSB +: 8];
	assign halt_irq = irq_hit(op_q, pend);
	assign halt_tmr = op_q[OP_TMR_BIT] && tmr_req;
	assign stop_irq = irq_hit(op_q, pend_stop);
	// Flags as they stand at the instruction; a clear must already have landed
	assign new_halt_wake = irq_hit(OPERAND_I, pend) || (OPERAND_I[OP_TMR_BIT] && tmr_req);
	assign new_stop_wake = irq_hit(OPERAND_I, pend_stop);

	always_comb begin
		state_d = state_q;
		op_d = op_q;
		cause_d = cause_q;
		sel_d = sel_q;
		vec_d = vec_q;
		pulse_d = 1'b0;
		init_d = 1'b0;
		cold_d = cold_q;
		wdiv_d = wdiv_q;
		wcnt_d = wcnt_q;
		tmr.start = 1'b0;
		tmr.div = wdiv_q;
		tmr.count = wcnt_q;
		if (rst_req) begin
			// Reset outranks every mode and always restarts at address zero
			state_d = ST_RESET;
			cause_d = CAUSE_RESET;
			sel_d = RES_ZERO;
			wdiv_d = RST_DIV;
			wcnt_d = RST_CNT;
		end else begin
			case (state_q)
				ST_RESET: begin
					tmr.start = 1'b1;
					if (cold_q) begin
						// Oscillator was off: let it settle first
						tmr.div = OSC_DIV;
						tmr.count = osc_q;
						state_d = ST_OSC;
					end else begin
						state_d = ST_WAIT;
					end
				end
				ST_RUN: begin
					if (HALT_EXEC_I) begin
						if (!new_halt_wake) begin
							state_d = ST_HALT;
							op_d = OPERAND_I;
						end
					end else if (STOP_EXEC_I) begin
						if (!new_stop_wake) begin
							state_d = ST_STOP;
							op_d = OPERAND_I;
							cold_d = 1'b1;
							// Restart wait settings captured at entry
							wdiv_d = (div_m == 8'h00) ? M_ZERO_DIV : {8'h00, div_m};
							wcnt_d = {8'h00, mod_n} + 16'h0001;
							init_d = (OPERAND_I == OP_RESET_ONLY);
						end
					end
				end
				ST_HALT: begin
					if (halt_irq || halt_tmr) begin
						state_d = ST_RUN;
						pulse_d = 1'b1;
						cause_d = halt_irq ? CAUSE_IRQ : CAUSE_TIMER;
						if (GLOBAL_INTERRUPTS_ENABLED_I && (|pend)) begin
							sel_d = RES_VEC;
							vec_d = first_src(pend);
						end else begin
							sel_d = RES_NEXT;
						end
					end
				end
				ST_STOP: begin
					if (stop_irq) begin
						state_d = ST_OSC;
						cause_d = CAUSE_IRQ;
						tmr.start = 1'b1;
						tmr.div = OSC_DIV;
						tmr.count = osc_q;
						if (GLOBAL_INTERRUPTS_ENABLED_I) begin
							sel_d = RES_VEC;
							vec_d = first_src(pend_stop);
						end else begin
							sel_d = RES_NEXT;
						end
					end
				end
				ST_OSC: begin
					if (tmr.done) begin
						cold_d = 1'b0;
						tmr.start = 1'b1;
						state_d = ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (tmr.done) begin
						state_d = ST_RUN;
						pulse_d = 1'b1;
					end
				end
				default: begin
					state_d = ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state_q <= ST_RESET;
			op_q <= OP_RESET_ONLY;
			cause_q <= CAUSE_NONE;
			sel_q <= RES_ZERO;
			vec_q <= '0;
			pulse_q <= 1'b0;
			init_q <= 1'b0;
			cold_q <= 1'b0;
			wdiv_q <= RST_DIV;
			wcnt_q <= RST_CNT;
		end else if (CLK_EN_I) begin
			state_q <= state_d;
			op_q <= op_d;
			cause_q <= cause_d;
			sel_q <= sel_d;
			vec_q <= vec_d;
			pulse_q <= pulse_d;
			init_q <= init_d;
			cold_q <= cold_d;
			wdiv_q <= wdiv_d;
			wcnt_q <= wcnt_d;
		end
	end

	assign CORE_CLK_EN_O = (state_q == ST_RUN);
	assign OSC_EN_O = (state_q != ST_STOP);
	assign HALT_MODE_O = (state_q == ST_HALT);
	assign STOP_MODE_O = (state_q == ST_STOP);
	assign INIT_O = init_q;
	assign RESUME_O = pulse_q;
	assign RESUME_SEL_O = sel_q;
	assign VECTOR_O = vec_q;

	// Register slave; zero wait states, so hready is never pulled low
	logic [15:0] ctrl_d, osc_d;
	logic wr_q, wr_d;
	logic [11:0] wa_q, wa_d;
	logic [31:0] rd_q, rd_d, stat_w;

	assign stat_w = {20'h0, cause_q, op_q, state_q};

	always_comb begin
		ctrl_d = ctrl_q;
		osc_d = osc_q;
		wr_d = 1'b0;
		wa_d = wa_q;
		rd_d = '0;
		if (wr_q) begin
			case (wa_q)
				CTRL_OFS: begin
					ctrl_d = HWDATA_I[15:0];
				end
				OSC_OFS: begin
					osc_d = HWDATA_I[15:0];
				end
				default: begin
				end
			endcase
		end
		if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
			wr_d = HWRITE_I;
			wa_d = HADDR_I[11:0];
			if (!HWRITE_I) begin
				// Next values, so a read right after a write sees it
				case (HADDR_I[11:0])
					CTRL_OFS: begin
						rd_d = {16'h0, ctrl_d};
					end
					OSC_OFS: begin
						rd_d = {16'h0, osc_d};
					end
					STAT_OFS: begin
						rd_d = stat_w;
					end
					default: begin
						rd_d = '0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ctrl_q <= CTRL_RST;
			osc_q <= OSC_RST;
			wr_q <= 1'b0;
			wa_q <= '0;
			rd_q <= '0;
		end else if (CLK_EN_I) begin
			ctrl_q <= ctrl_d;
			osc_q <= osc_d;
			wr_q <= wr_d;
			wa_q <= wa_d;
			rd_q <= rd_d;
		end
	end

	assign HRDATA_O = rd_q;
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
endmodule // standby_ctrl
`default_nettype wire

/* File: include/standby_pkg.sv */
// Shared constants and types for the standby sequencer and its restart timer.
// Assumes a single core clock; the bus offsets are byte addresses of 32-bit words.
package standby_pkg;
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] OSC_OFS = 12'h004;
	localparam logic [11:0] STAT_OFS = 12'h008;
	localparam int CTRL_N_LSB = 0;
	localparam int CTRL_M_LSB = 8;
	localparam logic [15:0] CTRL_RST = 16'h00ff;
	localparam logic [15:0] OSC_RST = 16'h0400;
	localparam logic [15:0] M_ZERO_DIV = 16'h0100;
	localparam logic [15:0] RST_DIV_DEF = 16'h0100;
	localparam logic [15:0] RST_CNT_DEF = 16'h0100;
	localparam logic [15:0] OSC_DIV = 16'h0001;
	localparam int OP_IRQ_BIT = 3;
	localparam int OP_TMR_BIT = 1;
	localparam logic [3:0] OP_RESET_ONLY = 4'h0;

	typedef enum logic [5:0] {
		ST_RUN = 6'h01,
		ST_HALT = 6'h02,
		ST_STOP = 6'h04,
		ST_RESET = 6'h08,
		ST_OSC = 6'h10,
		ST_WAIT = 6'h20
	} state_type;

	typedef enum logic [1:0] {
		RES_ZERO = 2'h0,
		RES_NEXT = 2'h1,
		RES_VEC = 2'h2
	} resume_type;

	typedef enum logic [1:0] {
		CAUSE_NONE = 2'h0,
		CAUSE_RESET = 2'h1,
		CAUSE_IRQ = 2'h2,
		CAUSE_TIMER = 2'h3
	} cause_type;
endpackage

/* File: include/standby_timer_if.sv */
// Link between the standby sequencer and its restart wait timer.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
`default_nettype none
interface standby_timer_if;
	logic start;
	logic [15:0] div;
	logic [15:0] count;
	logic done;
	modport ctrl (output start, output div, output count, input done);
	modport timer (input start, input div, input count, output done);
endinterface
`default_nettype wire

/* File: core/standby_wait_timer.sv */
// Restart wait timer: counts ticks of the core clock divided by div.
// Assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/1ps
`default_nettype none
module standby_wait_timer (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	standby_timer_if.timer tmr
);
	import standby_pkg::*;

	logic [15:0] pre_q, pre_d, cnt_q, cnt_d, div_q, div_d, lim_q, lim_d;
	logic busy_q, busy_d, done_q, done_d;

	assign tmr.done = done_q;

	always_comb begin
		pre_d = pre_q;
		cnt_d = cnt_q;
		div_d = div_q;
		lim_d = lim_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (tmr.start) begin
			pre_d = '0;
			cnt_d = '0;
			// Zero divider behaves as one so the wait cannot hang
			div_d = (tmr.div == '0) ? OSC_DIV : tmr.div;
			lim_d = tmr.count;
			busy_d = 1'b1;
		end else if (busy_q) begin
			if (pre_q + 16'h0001 >= div_q) begin
				pre_d = '0;
				cnt_d = cnt_q + 16'h0001;
				if (cnt_q + 16'h0001 >= lim_q) begin
					busy_d = 1'b0;
					done_d = 1'b1;
				end
			end else begin
				pre_d = pre_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pre_q <= '0;
			cnt_q <= '0;
			div_q <= OSC_DIV;
			lim_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (clk_en_i) begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			div_q <= div_d;
			lim_q <= lim_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end
endmodule // standby_wait_timer
`default_nettype wire

/* File: verif/standby_ctrl_chk.sv */
// Checker on the standby sequencer top ports: modes, wake refusal, resume pulse.
// Assumes binding to standby_ctrl with one core clock domain.
`timescale 1ns/1ps
`default_nettype none
module standby_ctrl_chk
	import standby_pkg::*;
#(
	parameter int unsigned NUM_SRC = 4
) (
	input wire logic CORE_CLK_I,
	input wire logic ARST_N_I,
	input wire logic CLK_EN_I,
	input wire logic HALT_EXEC_I,
	input wire logic STOP_EXEC_I,
	input wire logic [3:0] OPERAND_I,
	input wire logic [NUM_SRC-1:0] PERIPHERAL_REQUEST_FLAG_I,
	input wire logic [NUM_SRC-1:0] PERIPHERAL_WAKE_ENABLE_FLAG_I,
	input wire logic GLOBAL_INTERRUPTS_ENABLED_I,
	input wire logic CORE_CLK_EN_O,
	input wire logic OSC_EN_O,
	input wire logic HALT_MODE_O,
	input wire logic STOP_MODE_O,
	input wire logic INIT_O,
	input wire logic RESUME_O,
	input wire standby_pkg::resume_type RESUME_SEL_O
);
	logic run;
	logic pend;
	assign run = CLK_EN_I && CORE_CLK_EN_O;
	assign pend = |(PERIPHERAL_REQUEST_FLAG_I & PERIPHERAL_WAKE_ENABLE_FLAG_I);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!ARST_N_I);
	property p_halt_enter;
		run && HALT_EXEC_I && OPERAND_I == 4'h8 && !pend |=> HALT_MODE_O;
	endproperty
	a_halt_enter: assert property (p_halt_enter) else $error("halt not entered");
	property p_halt_nop;
		run && HALT_EXEC_I && OPERAND_I[3] && pend |=> !HALT_MODE_O && CORE_CLK_EN_O;
	endproperty
	a_halt_nop: assert property (p_halt_nop) else $error("halt not ignored");
	property p_timer_nop;
		run && HALT_EXEC_I && OPERAND_I[1] && PERIPHERAL_REQUEST_FLAG_I[0] |=> !HALT_MODE_O;
	endproperty
	a_timer_nop: assert property (p_timer_nop) else $error("timer halt not ignored");
	property p_init;
		run && STOP_EXEC_I && !HALT_EXEC_I && OPERAND_I == 4'h0 |=> INIT_O && STOP_MODE_O;
	endproperty
	a_init: assert property (p_init) else $error("stop zero no init");
	property p_halt_osc;
		HALT_MODE_O |-> OSC_EN_O && !CORE_CLK_EN_O;
	endproperty
	a_halt_osc: assert property (p_halt_osc) else $error("halt clocks wrong");
	property p_stop_osc;
		STOP_MODE_O |-> !OSC_EN_O && !CORE_CLK_EN_O;
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("stop clocks wrong");
	property p_resume;
		RESUME_O |-> CORE_CLK_EN_O ##1 !RESUME_O;
	endproperty
	a_resume: assert property (p_resume) else $error("resume pulse wrong");
	property p_vec;
		RESUME_O && RESUME_SEL_O == RES_VEC |-> $past(GLOBAL_INTERRUPTS_ENABLED_I);
	endproperty
	a_vec: assert property (p_vec) else $error("vector while disabled");
endmodule // standby_ctrl_chk
`default_nettype wire

/* File: verif/standby_core_model.sv */
// Core model: issues halt and stop instructions one cycle after a request.
// Assumes the core only executes while its clock enable is high.
`timescale 1ns/1ps
`default_nettype none
module standby_core_model (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic core_en_i,
	input wire logic go_halt_i,
	input wire logic go_stop_i,
	input wire logic [3:0] op_i,
	output logic halt_exec_o,
	output logic stop_exec_o,
	output logic [3:0] operand_o
);
	// The idle cycle stands for the no-operation before the instruction
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			halt_exec_o <= 1'b0;
			stop_exec_o <= 1'b0;
			operand_o <= 4'h0;
		end else begin
			halt_exec_o <= go_halt_i & core_en_i;
			stop_exec_o <= go_stop_i & core_en_i;
			// Operand is only meaningful with an execute pulse
			operand_o <= (go_halt_i | go_stop_i) ? op_i : ~operand_o;
		end
	end
endmodule // standby_core_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench: AHB register access and halt/stop entry and wake.
// Assumes short reset wait parameters and the core model beside the design.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import standby_pkg::*;
	logic clk, arst_n, hwrite, hready, hresp, pin_n, pwr_fail, go_h, go_s, gie, ce;
	logic halt_x, stop_x, core_en, osc_en, halt_m, stop_m, init, resume;
	logic [1:0] htrans, vec;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [3:0] op, opnd, req, en;
	resume_type sel;
	int fail_count, n_compared, cyc, n;
	standby_ctrl #(.RST_DIV(16'h0004), .RST_CNT(16'h0004)) dut_u (
		.CORE_CLK_I(clk), .ARST_N_I(arst_n), .CLK_EN_I(ce), .HSEL_I(1'b1),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
		.HREADYOUT_O(hready), .HRESP_O(hresp), .RESET_PIN_N_I(pin_n),
		.POWER_FAIL_I(pwr_fail), .HALT_EXEC_I(halt_x), .STOP_EXEC_I(stop_x),
		.OPERAND_I(opnd), .PERIPHERAL_REQUEST_FLAG_I(req),
		.PERIPHERAL_WAKE_ENABLE_FLAG_I(en), .GLOBAL_INTERRUPTS_ENABLED_I(gie),
		.CORE_CLK_EN_O(core_en), .OSC_EN_O(osc_en), .HALT_MODE_O(halt_m),
		.STOP_MODE_O(stop_m), .INIT_O(init), .RESUME_O(resume),
		.RESUME_SEL_O(sel), .VECTOR_O(vec));
	standby_core_model core_u (.clk_i(clk), .arst_n_i(arst_n), .core_en_i(core_en),
		.go_halt_i(go_h), .go_stop_i(go_s), .op_i(op), .halt_exec_o(halt_x),
		.stop_exec_o(stop_x), .operand_o(opnd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] v, input logic [31:0] e);
		n_compared++;
		if (v !== e) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, v, e);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		@(posedge clk);
		while (!hready) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (!hready) @(posedge clk);
		rd = hrdata;
	endtask
	task ex(input logic h, input logic [3:0] o);
		go_h <= h;
		go_s <= !h;
		op <= o;
		@(posedge clk);
		go_h <= 1'b0;
		go_s <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task wres;
		n = 0;
		while (resume !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk(32'(n < 3000), 32'h1);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		{arst_n, htrans, haddr, hwrite, hwdata, pwr_fail, go_h, go_s, op, req, en, gie} = '0;
		{pin_n, fail_count, n_compared, cyc} = '0;
		pin_n = 1'b1;
		ce = 1'b1;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		wres();
		chk(sel, RES_ZERO);
		// Register defaults, unmapped hole, read-only status
		bus(0, CTRL_OFS, 0);
		chk(rd, 32'h0000_00ff);
		bus(0, OSC_OFS, 0);
		chk(rd, 32'h0000_0400);
		bus(0, 12'h00c, 0);
		chk(rd, 32'h0);
		chk(hresp, 1'b0);
		bus(1, OSC_OFS, 32'h4);
		bus(1, CTRL_OFS, 32'h0201);
		bus(1, STAT_OFS, 32'hffff);
		bus(0, CTRL_OFS, 0);
		chk(rd, 32'h0201);
		bus(0, STAT_OFS, 0);
		chk(rd & 32'h3f, 32'h01);
		for (int g = 0; g < 2; g++) begin
			en <= 4'b1100;
			gie <= g[0];
			ex(1, 4'h8);
			chk(halt_m, 1);
			chk(osc_en, 1);
			req <= 4'b1100;
			wres();
			chk(sel, g ? RES_VEC : RES_NEXT);
			if (g) chk(vec, 2);
			req <= 4'h0;
		end
		en <= 4'h0;
		ex(1, 4'h2);
		chk(halt_m, 1);
		req <= 4'b0001;
		wres();
		chk(sel, RES_NEXT);
		req <= 4'b0101;
		en <= 4'b0100;
		ex(1, 4'ha);
		chk(halt_m, 0);
		chk(core_en, 1);
		ex(0, 4'h8);
		chk(stop_m, 0);
		for (int g = 0; g < 2; g++) begin
			req <= 4'h0;
			en <= 4'b0101;
			gie <= g[0];
			ex(0, 4'h8);
			chk(stop_m, 1);
			chk(osc_en, 0);
			req <= 4'b0001;
			repeat (20) @(posedge clk);
			chk(stop_m, 1);
			req <= 4'b0100;
			wres();
			chk(sel, g ? RES_VEC : RES_NEXT);
			// Osc 4 plus (1+1) ticks of 2 plus pipeline; n instead of n+1 gives 10
			chk(32'(n >= 11 && n <= 13), 32'h1);
			if (g) chk(vec, 2);
		end
		req <= 4'h0;
		en <= 4'h0;
		ex(0, 4'h0);
		chk(init, 1);
		chk(stop_m, 1);
		pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		pin_n <= 1'b1;
		wres();
		chk(sel, RES_ZERO);
		// Without the oscillator wait this would be about 21
		chk(32'(n >= 24 && n <= 28), 32'h1);
		en <= 4'b0100;
		req <= 4'b0100;
		ex(1, 4'h0);
		repeat (10) @(posedge clk);
		chk(halt_m, 1);
		// Frozen block must not even see a power-fail pulse
		ce <= 1'b0;
		pwr_fail <= 1'b1;
		repeat (4) @(posedge clk);
		pwr_fail <= 1'b0;
		repeat (4) @(posedge clk);
		chk(halt_m, 1);
		ce <= 1'b1;
		pwr_fail <= 1'b1;
		repeat (4) @(posedge clk);
		pwr_fail <= 1'b0;
		wres();
		chk(sel, RES_ZERO);
		// No oscillator wait after halt: sync plus 4 x 4 ticks
		chk(32'(n >= 19 && n <= 23), 32'h1);
		summarize();
	end
endmodule // testbench
bind standby_ctrl standby_ctrl_chk #(.NUM_SRC(NUM_SRC)) chk_u (.CORE_CLK_I, .ARST_N_I,
	.CLK_EN_I, .HALT_EXEC_I, .STOP_EXEC_I, .OPERAND_I, .PERIPHERAL_REQUEST_FLAG_I,
	.PERIPHERAL_WAKE_ENABLE_FLAG_I, .GLOBAL_INTERRUPTS_ENABLED_I, .CORE_CLK_EN_O,
	.OSC_EN_O, .HALT_MODE_O, .STOP_MODE_O, .INIT_O, .RESUME_O, .RESUME_SEL_O);
`default_nettype wire
